/* hdl/sdcd_controller.sv */
// Purpose: SDRAM controller between a shared address/data system bus and two x16 SDRAMs.
// Assumes: clock is the doubled clock; one bus word arrives per edge of it.
// Notes: Memory pins lag the state register by one cycle.
`timescale 1ns/1ns
`include "sdcd_defines.svh"
module sdcd_controller (
  input wire logic clock,
  input wire logic rst,
  input wire logic [31:0] adIn,
  output logic [31:0] adOut,
  output logic adOe,
  input wire logic busIsData,
  input wire logic writeReadSelect,
  output logic ctrlReady,
  input wire logic [31:0] memDqBusIn,
  output logic [31:0] memDqBusOut,
  output logic memDqBusOe,
  output logic [10:0] memAddrBus,
  output logic memBankSelect,
  output logic memRasN,
  output logic memCasN,
  output logic memWeN,
  output logic memChipSelectLoN,
  output logic memChipSelectHiN,
  output logic [3:0] memByteMasks,
  output logic memClockGate
);
  import sdcd_pkg::*;

  // Pin levels {cs, ras, cas, we} for each memory command.
  function automatic logic [3:0] cmdBits(input sdcd_cmd_t c);
    case (c)
      MC_ACT: cmdBits = 4'h3;
      MC_READ: cmdBits = 4'h5;
      MC_WRITE: cmdBits = 4'h4;
      MC_PRE: cmdBits = 4'h2;
      MC_REF: cmdBits = 4'h1;
      MC_MRS: cmdBits = 4'h0;
      default: cmdBits = 4'h7;
    endcase
  endfunction

  // ************************************************************
  // State and captured address
  // ************************************************************
  sdcd_state_t state_q, state_d;
  logic [`SDCD_CFG_W-1:0] cfg_q;
  logic cfgPending_q, cfgValid_q;
  logic bank_q, isWrite_q;
  logic [10:0] row_q, modeVal_q;
  logic [7:0] col_q;
  logic [3:0] wait_q, wait_d;
  logic [2:0] beat_q, beat_d;
  logic [3:0] rdCnt_q;
  logic [15:0] refCnt_q;
  logic refDue_q;
  logic wrCap_q;
  logic [2:0] capIdx_q;
  logic [31:0] wrBuf [0:7];

  // Config fields.
  wire [1:0] clField = cfg_q[`SDCD_CL_HI:`SDCD_CL_LO];
  wire [1:0] rcdField = cfg_q[`SDCD_RCD_HI:`SDCD_RCD_LO];
  wire [2:0] blField = cfg_q[`SDCD_BL_HI:`SDCD_BL_LO];
  wire [15:0] refField = cfg_q[`SDCD_REF_HI:`SDCD_REF_LO];
  wire [3:0] refWait = cfg_q[`SDCD_RWAIT_HI:`SDCD_RWAIT_LO];
  wire [3:0] casLat = {2'h0, clField} + 4'h1;
  wire [3:0] rdLast = casLat + {1'b0, blField};

  // Bus decode of address phases and data phases.
  wire addrPhase = ~busIsData;
  wire [1:0] opCode = adIn[`SDCD_OP_HI:`SDCD_OP_LO];
  wire cmdTake = (state_q == S_IDLE) && addrPhase;
  wire wrData = busIsData && writeReadSelect;
  wire cfgLoad = cfgPending_q && wrData;
  wire clrRef = (state_q == S_REF1);
  wire refTick = cfgValid_q && !clrRef && (refCnt_q == 16'h0000);
  wire rdCapture = (state_q == S_READ) && (rdCnt_q >= casLat) && (rdCnt_q <= rdLast);
  wire [2:0] beatSel = (state_q == S_WRITE_C) ? 3'h0 : beat_q;

  // Memory command for the current state.
  wire sdcd_cmd_t memCmd = (state_q == S_ACT) ? MC_ACT :
    (state_q == S_READ_C) ? MC_READ :
    (state_q == S_WRITE_C) ? MC_WRITE :
    (state_q == S_PRE) ? MC_PRE :
    (state_q == S_REF1) ? MC_REF :
    (state_q == S_MRS) ? MC_MRS : MC_NOP;
  wire isCol = (memCmd == MC_READ) || (memCmd == MC_WRITE);
  wire [10:0] addrD = (memCmd == MC_ACT) ? row_q :
    (memCmd == MC_MRS) ? modeVal_q :
    isCol ? {1'b1, 2'h0, col_q} :
    11'h400; // Precharge of all banks keeps A10 high.
  wire [3:0] pinD = cmdBits(memCmd);
  wire writeBeat = (state_q == S_WRITE_C) || (state_q == S_WRITE);

  // ************************************************************
  // Next state
  // ************************************************************
  // Sequencer: branch on the system command, then run the automatic sequence.
  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    beat_d = beat_q;
    case (state_q)
      S_IDLE: begin
        if (addrPhase) begin
          if (opCode == `SDCD_OP_RW) begin
            state_d = S_ACT;
          end else if (opCode == `SDCD_OP_MRS) begin
            state_d = S_MRS;
          end else if (opCode == `SDCD_OP_PRE) begin
            state_d = S_PRE;
          end else begin
            state_d = S_REF1;
          end
        end else if (refDue_q) begin
          state_d = S_REF1;
        end
      end
      S_PRE, S_MRS: begin
        state_d = S_RECOVER;
        wait_d = 4'(`SDCD_TRP_CYC);
      end
      S_REF1: state_d = S_REF2;
      S_REF2: begin
        state_d = S_RECOVER;
        wait_d = refWait;
      end
      S_ACT: begin
        if (isWrite_q) begin
          state_d = S_WRITE_W;
          wait_d = {2'h0, rcdField};
        end else if (rcdField == 2'h0) begin
          state_d = S_READ_CS;
        end else begin
          state_d = S_READ_W;
          wait_d = {2'h0, rcdField} - 4'h1;
        end
      end
      S_WRITE_W: begin
        if (wait_q == 4'h0) begin
          state_d = S_WRITE_C;
        end else begin
          wait_d = wait_q - 4'h1;
        end
      end
      S_WRITE_C: begin
        beat_d = 3'h1;
        if (blField == 3'h0) begin
          state_d = S_RECOVER;
          wait_d = 4'(`SDCD_TRP_CYC);
        end else begin
          state_d = S_WRITE;
        end
      end
      S_WRITE: begin
        beat_d = beat_q + 3'h1;
        if (beat_q == blField) begin
          state_d = S_RECOVER;
          wait_d = 4'(`SDCD_TRP_CYC);
        end
      end
      S_READ_W: begin
        if (wait_q == 4'h0) begin
          state_d = S_READ_CS;
        end else begin
          wait_d = wait_q - 4'h1;
        end
      end
      S_READ_CS: state_d = S_READ_C;
      S_READ_C: state_d = S_READ;
      S_READ: begin
        if (rdCnt_q == rdLast) begin
          state_d = S_RECOVER;
          wait_d = 4'(`SDCD_TRP_CYC);
        end
      end
      S_RECOVER: begin
        if (wait_q == 4'h0) begin
          state_d = S_IDLE;
        end else begin
          wait_d = wait_q - 4'h1;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Sequencer registers and the address captured in an address phase.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= S_IDLE;
      wait_q <= 4'h0;
      beat_q <= 3'h0;
      bank_q <= 1'b0;
      isWrite_q <= 1'b0;
      row_q <= 11'h000;
      col_q <= 8'h00;
      modeVal_q <= 11'h000;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      beat_q <= beat_d;
      if (cmdTake) begin
        bank_q <= adIn[`SDCD_BANK_BIT];
        row_q <= adIn[`SDCD_ROW_HI:`SDCD_ROW_LO];
        col_q <= adIn[`SDCD_COL_HI:`SDCD_COL_LO];
        modeVal_q <= adIn[`SDCD_ROW_HI:`SDCD_ROW_LO];
        isWrite_q <= writeReadSelect;
      end
    end
  end

  // Timing config load, armed by a precharge command.
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_q <= `SDCD_CFG_RESET;
      cfgPending_q <= 1'b0;
      cfgValid_q <= 1'b0;
    end else begin
      if (cfgLoad) begin
        cfg_q <= adIn[`SDCD_CFG_W-1:0];
        cfgValid_q <= 1'b1;
      end
      cfgPending_q <= (cfgPending_q && !wrData) || (cmdTake && (opCode == `SDCD_OP_PRE));
    end
  end

  // Refresh interval counter; a due tick that meets the clear is dropped.
  always_ff @(posedge clock) begin
    if (rst) begin
      refCnt_q <= 16'h0000;
      refDue_q <= 1'b0;
    end else begin
      if (clrRef || !cfgValid_q || refTick) begin
        refCnt_q <= refField;
      end else begin
        refCnt_q <= refCnt_q - 16'h0001;
      end
      refDue_q <= (refDue_q && !clrRef) || refTick;
    end
  end

  // Write word capture index: one word per edge after a write address phase.
  always_ff @(posedge clock) begin
    if (rst) begin
      wrCap_q <= 1'b0;
      capIdx_q <= 3'h0;
    end else if (cmdTake && (opCode == `SDCD_OP_RW) && writeReadSelect) begin
      wrCap_q <= 1'b1;
      capIdx_q <= 3'h0;
    end else if (wrCap_q && wrData) begin
      capIdx_q <= capIdx_q + 3'h1;
      wrCap_q <= (capIdx_q != blField);
    end
  end

  // Write burst buffer, each word filled ahead of the beat that sends it.
  always_ff @(posedge clock) begin
    if (wrCap_q && wrData) begin
      wrBuf[capIdx_q] <= adIn;
    end
  end

  // Read beat counter, started with the read column command.
  always_ff @(posedge clock) begin
    if (rst) begin
      rdCnt_q <= 4'h0;
    end else if (state_q == S_READ_C) begin
      rdCnt_q <= 4'h0;
    end else if (state_q == S_READ) begin
      rdCnt_q <= rdCnt_q + 4'h1;
    end
  end

  // ************************************************************
  // Output registers
  // ************************************************************
  // Memory pins: command, address, data; both chips share one command.
  always_ff @(posedge clock) begin
    if (rst) begin
      {memChipSelectLoN, memRasN, memCasN, memWeN} <= 4'hf;
      memChipSelectHiN <= 1'b1;
      memAddrBus <= 11'h000;
      memBankSelect <= 1'b0;
      memDqBusOut <= 32'h00000000;
      memDqBusOe <= 1'b0;
      memByteMasks <= 4'hf;
      memClockGate <= 1'b0;
    end else begin
      {memChipSelectLoN, memRasN, memCasN, memWeN} <= pinD;
      memChipSelectHiN <= pinD[3];
      memAddrBus <= addrD;
      memBankSelect <= (memCmd == MC_MRS) ? 1'b0 : bank_q;
      memDqBusOut <= wrBuf[beatSel];
      memDqBusOe <= writeBeat;
      memByteMasks <= 4'h0;
      memClockGate <= 1'b1;
    end
  end

  // System side: read words onto the bus and the ready level.
  always_ff @(posedge clock) begin
    if (rst) begin
      adOut <= 32'h00000000;
      adOe <= 1'b0;
      ctrlReady <= 1'b0;
    end else begin
      if (rdCapture) begin
        adOut <= memDqBusIn;
      end
      adOe <= rdCapture;
      ctrlReady <= (state_d == S_IDLE);
    end
  end
endmodule

/* hdl/sdcd_defines.svh */
// Purpose: Constants for the DDR host port SDRAM controller.
// Assumes: One 50 MHz clock that is the doubled (memory side) clock.
// Notes: Field positions of the controller timing config and bus decode.
`ifndef SDCD_DEFINES_SVH
`define SDCD_DEFINES_SVH
// Clock rate and fixed precharge recovery time.
`define SDCD_CLK_MHZ 50
`define SDCD_TRP_NS 20
`define SDCD_TRP_CYC (((`SDCD_TRP_NS * `SDCD_CLK_MHZ) + 999) / 1000)
// System bus command field and codes.
`define SDCD_OP_HI 29
`define SDCD_OP_LO 28
`define SDCD_OP_RW 2'h0
`define SDCD_OP_MRS 2'h1
`define SDCD_OP_PRE 2'h2
`define SDCD_OP_REF 2'h3
// System address mapping.
`define SDCD_BANK_BIT 21
`define SDCD_ROW_HI 20
`define SDCD_ROW_LO 10
`define SDCD_COL_HI 9
`define SDCD_COL_LO 2
// Controller timing config fields and reset value.
`define SDCD_CFG_W 28
`define SDCD_CFG_RESET 28'h0000000
`define SDCD_CL_HI 1
`define SDCD_CL_LO 0
`define SDCD_RCD_HI 3
`define SDCD_RCD_LO 2
`define SDCD_BL_HI 6
`define SDCD_BL_LO 4
`define SDCD_REF_HI 23
`define SDCD_REF_LO 8
`define SDCD_RWAIT_HI 27
`define SDCD_RWAIT_LO 24
// Memory address bit that asks for automatic precharge.
`define SDCD_AP_BIT 10
`endif

/* hdl/sdcd_pkg.sv */
// Purpose: Types for the DDR host port SDRAM controller.
// Assumes: Nothing beyond the defines header.
// Notes: Memory commands are turned into pin levels by a function.
package sdcd_pkg;
  typedef enum logic [2:0] {
    MC_NOP, MC_ACT, MC_READ, MC_WRITE, MC_PRE, MC_REF, MC_MRS
  } sdcd_cmd_t;
  typedef enum logic [3:0] {
    S_IDLE, S_PRE, S_MRS, S_REF1, S_REF2, S_ACT, S_WRITE_W, S_WRITE_C,
    S_WRITE, S_READ_W, S_READ_CS, S_READ_C, S_READ, S_RECOVER
  } sdcd_state_t;
endpackage

/* dv/sdcd_monitor.sv */
// Purpose: Pin level checks for the SDRAM controller.
// Assumes: Pin command code is {cs, ras, cas, we}, all active low.
// Notes: Bound to every controller instance.
`timescale 1ns/1ns
module sdcd_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic [31:0] adIn,
  input wire logic [31:0] adOut,
  input wire logic adOe,
  input wire logic busIsData,
  input wire logic ctrlReady,
  input wire logic [31:0] memDqBusIn,
  input wire logic memDqBusOe,
  input wire logic [10:0] memAddrBus,
  input wire logic memBankSelect,
  input wire logic memRasN,
  input wire logic memCasN,
  input wire logic memWeN,
  input wire logic memChipSelectLoN
);
  // Decoded pin command, taken address phase and address fields.
  wire logic [3:0] pinCmd = {memChipSelectLoN, memRasN, memCasN, memWeN};
  wire logic take = ctrlReady && !busIsData;
  wire logic [1:0] op = adIn[29:28];
  wire logic [10:0] rowBits = adIn[20:10];
  wire logic bankBit = adIn[21];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ***************************
  // Command and data checks
  // ***************************
  a_read_autoclose: assert property (pinCmd == 4'h5 |-> memAddrBus[10])
    else $error("read column command not autoclosed");
  a_write_autoclose: assert property (pinCmd == 4'h4 |-> memAddrBus[10] && memDqBusOe)
    else $error("write column command malformed");
  a_col_after_open: assert property (pinCmd[3:1] == 3'h2 |->
    $past(pinCmd, 2) == 4'h3 || $past(pinCmd, 3) == 4'h3)
    else $error("column command too soon after row open");
  a_open_mapping: assert property (take && op == 2'h0 |-> ##2 pinCmd == 4'h3
    && memAddrBus == $past(rowBits, 2) && memBankSelect == $past(bankBit, 2))
    else $error("row open wrong");
  a_mode_forward: assert property (take && op == 2'h1 |-> ##2 pinCmd == 4'h0
    && memAddrBus == $past(rowBits, 2))
    else $error("mode set wrong");
  a_refresh_issue: assert property (take && op == 2'h3 |-> ##2 pinCmd == 4'h1)
    else $error("refresh not issued");
  a_precharge_all: assert property (take && op == 2'h2 |-> ##2 pinCmd == 4'h2 && memAddrBus[10])
    else $error("precharge all not issued");
  a_idle_nop: assert property ($past(ctrlReady) |-> pinCmd == 4'h7)
    else $error("idle cycle without no-operation");
  a_read_data: assert property (adOe |-> adOut == $past(memDqBusIn))
    else $error("read word not forwarded");
  a_read_start: assert property (pinCmd == 4'h5 |-> ##[3:4] adOe)
    else $error("read data late");
endmodule
bind sdcd_controller sdcd_monitor mon_u (.clock(clock), .rst(rst), .adIn(adIn), .adOut(adOut), .adOe(adOe),
  .busIsData(busIsData), .ctrlReady(ctrlReady), .memDqBusIn(memDqBusIn), .memDqBusOe(memDqBusOe),
  .memAddrBus(memAddrBus), .memBankSelect(memBankSelect), .memRasN(memRasN), .memCasN(memCasN),
  .memWeN(memWeN), .memChipSelectLoN(memChipSelectLoN));

/* dv/sdcd_mem_model.sv */
// Purpose: Behavioural pair of x16 memories seen as one 32-bit device.
// Assumes: Bursts run in order from an aligned column.
// Notes: A released data bus toggles so stale words never match.
`timescale 1ns/1ns
module sdcd_mem_model (
  input wire logic clock,
  input wire logic [3:0] cmdPins,
  input wire logic [10:0] addr,
  input wire logic [31:0] dqOut,
  input wire logic dqOe,
  input wire logic [3:0] latency,
  input wire logic [3:0] burstLen,
  output logic [31:0] dqIn
);
  logic [31:0] mem [256];
  logic [7:0] wrPtr = 8'h0;
  logic [7:0] rdPtr = 8'h0;
  int rdWait = 0;
  int rdLeft = 0;
  initial dqIn = 32'h5a5a5a5a;
  // ***************************
  // Storage and read playback
  // ***************************
  // Write beats land from the column of the write command onward.
  always @(posedge clock) begin
    if (cmdPins == 4'h4) begin
      mem[addr[7:0]] <= dqOut;
      wrPtr <= addr[7:0] + 8'h1;
    end else if (dqOe) begin
      mem[wrPtr] <= dqOut;
      wrPtr <= wrPtr + 8'h1;
    end
  end
  // Read words change one cycle before the edge that the latency names.
  always @(posedge clock) begin
    if (cmdPins == 4'h5) begin
      rdPtr <= addr[7:0];
      rdWait = latency - 1;
      rdLeft = burstLen;
    end else if (rdLeft > 0 && rdWait > 1) begin
      rdWait--;
    end else if (rdLeft > 0) begin
      dqIn <= mem[rdPtr];
      rdPtr <= rdPtr + 8'h1;
      rdLeft--;
    end else begin
      dqIn <= ~dqIn;
    end
  end
endmodule

/* dv/sdcd_controller_tb_top.sv */
// Purpose: Self-checking bench for the SDRAM controller.
// Assumes: Bus inputs change on the rising clock edge.
// Notes: Rows set the config, write a burst and read it back.
`timescale 1ns/1ns
`include "sdcd_defines.svh"
module sdcd_controller_tb_top;
  typedef struct packed {logic [2:0] bl; logic [1:0] cl; logic [27:0] addr; logic [31:0] base;} sdcd_row_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic busIsData = 1'b1;
  logic writeReadSelect = 1'b0;
  logic [31:0] adIn = 32'h0;
  logic [3:0] modelLat = 4'h2;
  logic [3:0] modelLen = 4'h8;
  logic [31:0] adOut, memDqBusIn, memDqBusOut;
  logic [10:0] memAddrBus;
  logic [3:0] memByteMasks;
  logic adOe, ctrlReady, memDqBusOe, memBankSelect, memRasN, memCasN, memWeN;
  logic memChipSelectLoN, memChipSelectHiN, memClockGate;
  wire logic [3:0] pinCmd = {memChipSelectLoN, memRasN, memCasN, memWeN};
  int badCount = 0;
  int nCompared = 0;
  int n, hits;
  sdcd_row_t rows [4] = '{'{3'h7, 2'h1, 28'h0200c20, 32'h11110000}, '{3'h3, 2'h2, 28'h01ffc00, 32'h2222a000},
    '{3'h1, 2'h1, 28'h02003e0, 32'h3333b000}, '{3'h0, 2'h2, 28'h0000400, 32'h4444c000}};
  always #10 clock = ~clock;
  sdcd_controller dut_u (.clock(clock), .rst(rst), .adIn(adIn), .adOut(adOut), .adOe(adOe),
    .busIsData(busIsData), .writeReadSelect(writeReadSelect), .ctrlReady(ctrlReady),
    .memDqBusIn(memDqBusIn), .memDqBusOut(memDqBusOut), .memDqBusOe(memDqBusOe),
    .memAddrBus(memAddrBus), .memBankSelect(memBankSelect), .memRasN(memRasN), .memCasN(memCasN),
    .memWeN(memWeN), .memChipSelectLoN(memChipSelectLoN), .memChipSelectHiN(memChipSelectHiN),
    .memByteMasks(memByteMasks), .memClockGate(memClockGate));
  sdcd_mem_model mem_u (.clock(clock), .cmdPins(pinCmd), .addr(memAddrBus), .dqOut(memDqBusOut),
    .dqOe(memDqBusOe), .latency(modelLat), .burstLen(modelLen), .dqIn(memDqBusIn));
  // ***************************
  // Bus tasks
  // ***************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finalReport();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Holds an address phase until the edge that takes it, then starts the data phase.
  task automatic busOp(input logic [1:0] op, input logic rw, input logic [27:0] low, input logic [31:0] dat);
    adIn <= {2'h0, op, low};
    busIsData <= 1'b0;
    writeReadSelect <= rw;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ctrlReady !== 1'b1 && n < 300);
    check("address taken", 32'(n < 300), 32'h1);
    busIsData <= 1'b1;
    adIn <= dat;
  endtask
  // Ends a write data phase and lets one more edge pass before the next request.
  task automatic endPhase();
    @(posedge clock);
    writeReadSelect <= 1'b0;
    @(posedge clock);
  endtask
  // Loads the config and memory mode, writes one burst and reads it back.
  task automatic runRow(input sdcd_row_t r, input logic rcd, input logic [15:0] refCnt, input logic [3:0] hold);
    modelLat <= 4'(r.cl) + 4'h1;
    modelLen <= 4'(r.bl) + 4'h1;
    busOp(`SDCD_OP_PRE, 1'b1, 28'h0, {4'h0, hold, refCnt, 1'b0, r.bl, 1'b0, rcd, r.cl});
    endPhase();
    busOp(`SDCD_OP_MRS, 1'b1, {11'h0, 3'(r.cl + 1), 1'b0, 3'($clog2(r.bl + 1)), 10'h0}, 32'h0);
    endPhase();
    busOp(`SDCD_OP_RW, 1'b1, r.addr, r.base);
    for (int k = 1; k <= r.bl; k++) begin
      @(posedge clock);
      adIn <= r.base + k;
    end
    endPhase();
    busOp(`SDCD_OP_RW, 1'b0, r.addr, 32'h0);
    hits = 0;
    repeat (40) begin
      @(posedge clock);
      if (adOe === 1'b1) begin
        check("read word", adOut, r.base + hits);
        hits++;
      end
    end
    check("read beats", hits, r.bl + 1);
  endtask
  // ***************************
  // Main sequence
  // ***************************
  initial begin
    repeat (3) @(posedge clock);
    check("clock gate in reset", memClockGate, 1'b0);
    check("ready in reset", ctrlReady, 1'b0);
    check("masks in reset", memByteMasks, 4'hf);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    check("clock gate after reset", memClockGate, 1'b1);
    check("idle command", pinCmd, 4'h7);
    check("high select idle", memChipSelectHiN, 1'b0);
    check("masks after reset", memByteMasks, 4'h0);
    foreach (rows[i]) runRow(rows[i], i[0], 16'h0400, 4'h2);
    // An explicit refresh keeps the machine busy for the programmed wait.
    runRow(rows[1], 1'b1, 16'h0400, 4'h9);
    busOp(`SDCD_OP_REF, 1'b1, 28'h0, 32'h0);
    writeReadSelect <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ctrlReady !== 1'b1 && n < 40);
    check("refresh wait", 32'(n >= 11 && n <= 16), 32'h1);
    // A short interval makes the idle controller refresh on its own.
    runRow(rows[2], 1'b0, 16'h0030, 4'h2);
    // A refresh reloads the interval counter, which a config load alone leaves running.
    busOp(`SDCD_OP_REF, 1'b1, 28'h0, 32'h0);
    hits = 0;
    repeat (300) begin
      @(posedge clock);
      hits += (pinCmd == 4'h1);
    end
    check("periodic refreshes", 32'(hits >= 4 && hits <= 7), 32'h1);
    // Reset in mid-read deselects the memory and drops the config.
    busOp(`SDCD_OP_RW, 1'b0, rows[0].addr, 32'h0);
    repeat (5) @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    check("deselect in reset", memChipSelectLoN, 1'b1);
    check("high deselect in reset", memChipSelectHiN, 1'b1);
    check("read data in reset", adOe, 1'b0);
    rst <= 1'b0;
    hits = 0;
    repeat (200) begin
      @(posedge clock);
      hits += (pinCmd == 4'h1);
    end
    check("refresh before config", hits, 32'h0);
    check("ready after reset", ctrlReady, 1'b1);
    finalReport();
  end
  // Cuts a hang short well after the expected run length.
  initial begin
    repeat (6000) @(posedge clock);
    badCount++;
    finalReport();
  end
endmodule
